// >>> src/iec_bus_if.sv
`default_nettype none
interface iec_bus_if;
  logic scl_lvl;
  logic sda_lvl;
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;
  logic bus_busy;
  modport det (output scl_lvl, sda_lvl, start_det, stop_det, scl_rise,
               scl_fall, bus_busy);
  modport eng (input scl_lvl, sda_lvl, start_det, stop_det, scl_rise,
               scl_fall, bus_busy);
endinterface
`default_nettype wire

// >>> src/iec_enable_exit_ctrl.sv
// The APB register port was chosen for this implementation.
`default_nettype none
// Functional notes
// R1: Control register resets to zero.
// R2: Eight control bits at fixed address.
// R3: Software writes single bits or bytes.
// R4: Config bits change only disabled or stretching.
// R5: Config bits accepted with enable rising.
// R6: Disabled: status held reset, engine stopped.
// R7: Software enables only with both lines high.
// R8: Enable changes only by write or reset.
// R9: Exit abandons transfer, standby, self-clears.
// R10: Exit releases clock and data lines.
// R11: Exit clears triggers and status flags; code keeps the stop flag and sets standby.
// R12: Standby ignores bus until participation condition.
// R13: Stop detection ends standby, master capable.
// R14: Address match or extension ends standby.
// R15: Software exits on foreign extension code.
// R16: Exit set by write, cleared automatically.
// R17: Release bit ends stretch, self-clears.
// R18: Stop interrupt unless wakeup mode set.
// R19: Start and stop triggers generate conditions.
// R20: Wait timing zero interrupts at 8th fall.
// R21: Disable wins over simultaneous exit.
module iec_enable_exit_ctrl (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Async reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [19:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic scl_in, // Clock line level
  output logic scl_out, // Clock line drive value
  output logic scl_oe, // Clock line drive enable
  input wire logic sda_in, // Data line level
  output logic sda_out, // Data line drive value
  output logic sda_oe, // Data line drive enable
  output logic transfer_irq, // Transfer interrupt pulse
  output logic stop_irq // Stop condition interrupt pulse
);
  iec_bus_if bus ();

  iec_line_detect u_detect (
    .clk(clk),
    .sys_rst(sys_rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .bus(bus)
  );

  logic enable_reg;
  logic exit_reg;
  logic release_reg;
  logic stop_ie_reg;
  logic wait_timing_reg;
  logic ack_enable_reg;
  logic start_reg;
  logic stop_reg;
  logic [6:0] own_addr_reg;
  logic wakeup_reg;
  logic master_reg;
  logic match_reg;
  logic ext_reg;
  logic trc_reg;
  logic ackd_reg;
  logic std_reg;
  logic spd_reg;
  logic standby_reg;
  iec_pkg::iec_state_e state_reg;
  logic [7:0] timer_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic addr_phase_reg;
  logic stretch_reg;
  logic scl_drv_reg;
  logic sda_drv_reg;
  logic ack_drv_reg;
  logic xfer_irq_reg;
  logic stop_irq_reg;
  logic [31:0] prdata_reg;

  // Bus decode
  wire setup_phase = psel & ~penable;
  wire access_phase = psel & penable;
  wire hit_ctl = paddr == iec_pkg::ADDR_CONTROL_0; // R2
  wire hit_sts = paddr == iec_pkg::ADDR_STATUS;
  wire hit_cfg = paddr == iec_pkg::ADDR_CONFIG;
  wire hit_any = hit_ctl | hit_sts | hit_cfg;
  wire wr_lane = access_phase & pwrite & pstrb[0];
  wire wr_ctl = wr_lane & hit_ctl;
  wire wr_cfg = wr_lane & hit_cfg;
  wire [7:0] wdat = pwdata[7:0];
  wire [7:0] ctl_value = {enable_reg, exit_reg, release_reg, stop_ie_reg,
                          wait_timing_reg, ack_enable_reg, start_reg,
                          stop_reg};
  wire [7:0] sts_value = {master_reg, match_reg, ext_reg, trc_reg, ackd_reg,
                          std_reg, spd_reg, standby_reg};
  wire [7:0] cfg_value = {own_addr_reg, wakeup_reg};
  wire [7:0] rd_mux = hit_ctl ? ctl_value :
                      hit_sts ? sts_value :
                      hit_cfg ? cfg_value : 8'h00;

  // Control qualifiers
  wire en_rise = wr_ctl & wdat[iec_pkg::CTL_ENABLE] & ~enable_reg;
  wire cfg_ok = ~enable_reg | stretch_reg | en_rise; // R4 R5
  wire wr_enabled = wr_ctl & wdat[iec_pkg::CTL_ENABLE];
  wire exit_go = exit_reg & enable_reg; // R9
  wire gen_idle = state_reg == iec_pkg::ST_IDLE;
  wire timer_done = timer_reg == 8'h00;
  wire stop_go = enable_reg & ~exit_go & stop_reg &
                 (gen_idle | state_reg == iec_pkg::ST_MASTER);
  wire start_go = enable_reg & ~exit_go & start_reg & ~stop_reg & gen_idle &
                  ~bus.bus_busy & ~standby_reg;
  wire start_clr = ~enable_reg | exit_go | start_go;
  wire stop_clr = ~enable_reg | exit_go | stop_go;

  // Address byte evaluation at the 8th falling edge
  wire addr_match = shift_reg[7:1] == own_addr_reg;
  wire ext_code = shift_reg[7:3] == iec_pkg::EXT_CODE;
  wire eighth_fall = bus.scl_fall & bit_cnt_reg == iec_pkg::CNT_LAST_DATA;
  wire ninth_fall = bus.scl_fall & bit_cnt_reg == iec_pkg::CNT_ACK;
  wire hit_now = addr_phase_reg & (addr_match | ext_code);
  wire part_now = ~standby_reg & (master_reg | match_reg);
  wire part_8th = part_now | hit_now;
  wire trc_8th = addr_phase_reg ? (addr_match & shift_reg[0]) : trc_reg;
  wire slave_run = gen_idle;

  assign pready = 1'b1;
  assign pslverr = access_phase & ~hit_any;
  assign prdata = prdata_reg;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  // Open drain: only low is ever driven
  assign scl_oe = scl_drv_reg | stretch_reg; // R10
  assign sda_oe = sda_drv_reg | ack_drv_reg; // R10
  assign transfer_irq = xfer_irq_reg;
  assign stop_irq = stop_irq_reg;

  // Read data is captured in the setup cycle so it comes from a flop
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup_phase & ~pwrite) begin
      prdata_reg <= {24'h00_0000, rd_mux};
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      enable_reg <= iec_pkg::CONTROL_RESET[iec_pkg::CTL_ENABLE]; // R1
    end else if (wr_ctl) begin
      enable_reg <= wdat[iec_pkg::CTL_ENABLE]; // R8
    end
  end

  // An exit written together with a disable is dropped
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      exit_reg <= iec_pkg::CONTROL_RESET[iec_pkg::CTL_EXIT];
    end else if (wr_enabled & wdat[iec_pkg::CTL_EXIT]) begin
      exit_reg <= 1'b1; // R16 R21
    end else if (exit_reg) begin
      exit_reg <= 1'b0; // R9 R16
    end
  end

  // Release lives one cycle, the engine drops the stretch in that cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      release_reg <= iec_pkg::CONTROL_RESET[iec_pkg::CTL_RELEASE];
    end else begin
      release_reg <= wr_enabled & wdat[iec_pkg::CTL_RELEASE]; // R17
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stop_ie_reg <= iec_pkg::CONTROL_RESET[iec_pkg::CTL_STOP_IE];
      wait_timing_reg <= iec_pkg::CONTROL_RESET[iec_pkg::CTL_WAIT_TIMING];
      ack_enable_reg <= iec_pkg::CONTROL_RESET[iec_pkg::CTL_ACK_ENABLE];
    end else if (wr_ctl & cfg_ok) begin
      stop_ie_reg <= wdat[iec_pkg::CTL_STOP_IE]; // R4 R5
      wait_timing_reg <= wdat[iec_pkg::CTL_WAIT_TIMING];
      ack_enable_reg <= wdat[iec_pkg::CTL_ACK_ENABLE];
    end
  end

  // A new trigger write wins over a clear in the same cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      start_reg <= iec_pkg::CONTROL_RESET[iec_pkg::CTL_START];
      stop_reg <= iec_pkg::CONTROL_RESET[iec_pkg::CTL_STOP];
    end else begin
      if (wr_enabled & wdat[iec_pkg::CTL_START]) begin
        start_reg <= 1'b1; // R19
      end else if (start_clr) begin
        start_reg <= 1'b0; // R11
      end
      if (wr_enabled & wdat[iec_pkg::CTL_STOP]) begin
        stop_reg <= 1'b1; // R19
      end else if (stop_clr) begin
        stop_reg <= 1'b0; // R11
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      own_addr_reg <= iec_pkg::CONFIG_RESET[7:iec_pkg::CFG_ADDR_LSB];
      wakeup_reg <= iec_pkg::CONFIG_RESET[iec_pkg::CFG_WAKEUP];
    end else if (wr_cfg) begin
      own_addr_reg <= wdat[7:iec_pkg::CFG_ADDR_LSB];
      wakeup_reg <= wdat[iec_pkg::CFG_WAKEUP];
    end
  end

  // Start and stop generation
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= iec_pkg::ST_IDLE;
      timer_reg <= 8'h00;
      scl_drv_reg <= 1'b0;
      sda_drv_reg <= 1'b0;
    end else if (~enable_reg | exit_go) begin
      state_reg <= iec_pkg::ST_IDLE; // R6 R9
      timer_reg <= 8'h00;
      scl_drv_reg <= 1'b0; // R10
      sda_drv_reg <= 1'b0; // R10
    end else if (stop_go) begin
      state_reg <= iec_pkg::ST_STOP_LOW; // R19
      timer_reg <= iec_pkg::HOLD_CYCLES;
      scl_drv_reg <= 1'b1;
      sda_drv_reg <= 1'b1;
    end else if (start_go) begin
      state_reg <= iec_pkg::ST_START_HOLD; // R19
      timer_reg <= iec_pkg::HOLD_CYCLES;
      sda_drv_reg <= 1'b1;
    end else if (~timer_done) begin
      timer_reg <= timer_reg - 8'h01;
    end else begin
      case (state_reg)
        iec_pkg::ST_START_HOLD: begin
          scl_drv_reg <= 1'b1;
          state_reg <= iec_pkg::ST_MASTER;
        end
        iec_pkg::ST_STOP_LOW: begin
          scl_drv_reg <= 1'b0;
          timer_reg <= iec_pkg::HOLD_CYCLES;
          state_reg <= iec_pkg::ST_STOP_HIGH;
        end
        iec_pkg::ST_STOP_HIGH: begin
          sda_drv_reg <= 1'b0;
          state_reg <= iec_pkg::ST_IDLE;
        end
        iec_pkg::ST_MASTER: begin
          state_reg <= iec_pkg::ST_MASTER;
        end
        default: begin
          state_reg <= iec_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Byte framing, acknowledge and stretch
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      addr_phase_reg <= 1'b0;
      stretch_reg <= 1'b0;
      ack_drv_reg <= 1'b0;
    end else if (~enable_reg | exit_go) begin
      bit_cnt_reg <= 4'h0; // R6 R9
      shift_reg <= 8'h00;
      addr_phase_reg <= 1'b0;
      stretch_reg <= 1'b0; // R10
      ack_drv_reg <= 1'b0; // R10
    end else if (bus.start_det | bus.stop_det) begin
      bit_cnt_reg <= 4'h0;
      addr_phase_reg <= bus.start_det;
      stretch_reg <= 1'b0;
      ack_drv_reg <= 1'b0;
    end else begin
      if (release_reg) begin
        stretch_reg <= 1'b0; // R17
      end
      if (slave_run & bus.scl_rise & bit_cnt_reg < iec_pkg::CNT_ACK) begin
        shift_reg <= {shift_reg[6:0], bus.sda_lvl};
      end
      if (slave_run & eighth_fall) begin
        bit_cnt_reg <= iec_pkg::CNT_ACK;
        ack_drv_reg <= ack_enable_reg & part_8th & ~trc_8th;
        stretch_reg <= ~wait_timing_reg & part_8th; // R20
      end
      if (slave_run & bus.scl_fall & bit_cnt_reg < iec_pkg::CNT_LAST_DATA) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
      if (slave_run & ninth_fall) begin
        bit_cnt_reg <= 4'h0;
        addr_phase_reg <= 1'b0;
        ack_drv_reg <= 1'b0;
        stretch_reg <= wait_timing_reg & part_now;
      end
    end
  end

  // Status flags, held at reset while disabled
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {master_reg, match_reg, ext_reg, trc_reg, ackd_reg, std_reg, spd_reg,
       standby_reg} <= iec_pkg::STATUS_RESET;
    end else if (~enable_reg) begin
      {master_reg, match_reg, ext_reg, trc_reg, ackd_reg, std_reg, spd_reg,
       standby_reg} <= iec_pkg::STATUS_RESET; // R6 R21
    end else if (exit_go) begin
      master_reg <= 1'b0; // R11
      match_reg <= 1'b0;
      ext_reg <= 1'b0;
      trc_reg <= 1'b0;
      ackd_reg <= 1'b0;
      std_reg <= 1'b0;
      standby_reg <= 1'b1; // R9 R12
    end else if (bus.stop_det) begin
      master_reg <= 1'b0;
      match_reg <= 1'b0;
      ext_reg <= 1'b0;
      trc_reg <= 1'b0;
      std_reg <= 1'b0;
      spd_reg <= 1'b1;
      standby_reg <= 1'b0; // R13
    end else if (bus.start_det) begin
      std_reg <= 1'b1;
      spd_reg <= 1'b0;
      match_reg <= 1'b0;
      ext_reg <= 1'b0;
      trc_reg <= 1'b0;
    end else begin
      if (state_reg == iec_pkg::ST_START_HOLD & timer_done) begin
        master_reg <= 1'b1;
      end
      if (slave_run & eighth_fall & addr_phase_reg) begin
        match_reg <= addr_match;
        ext_reg <= ext_code;
        trc_reg <= addr_match & shift_reg[0];
        if (addr_match | ext_code) begin
          standby_reg <= 1'b0; // R14
        end
      end
      if (slave_run & bus.scl_rise & bit_cnt_reg == iec_pkg::CNT_ACK) begin
        ackd_reg <= ~bus.sda_lvl & ~ack_drv_reg;
      end
    end
  end

  // Interrupt pulses
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      xfer_irq_reg <= 1'b0;
      stop_irq_reg <= 1'b0;
    end else begin
      xfer_irq_reg <= enable_reg & ~exit_go & slave_run &
                      ((eighth_fall & ~wait_timing_reg & part_8th) | // R20
                       (ninth_fall & wait_timing_reg & part_now));
      stop_irq_reg <= enable_reg & bus.stop_det & stop_ie_reg &
                      ~wakeup_reg; // R18
    end
  end
endmodule
`default_nettype wire

// >>> src/iec_line_detect.sv
`default_nettype none
module iec_line_detect (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Async reset
  input wire logic scl_in, // Clock line level
  input wire logic sda_in, // Data line level
  iec_bus_if.det bus // Detected line events
);
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic scl_last_reg;
  logic sda_last_reg;
  logic busy_reg;
  logic skip_fall_reg;

  // Lines idle high, so reset to high avoids a false edge at release
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_sync_reg <= 2'b11;
      sda_sync_reg <= 2'b11;
      scl_last_reg <= 1'b1;
      sda_last_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_last_reg <= scl_sync_reg[1];
      sda_last_reg <= sda_sync_reg[1];
    end
  end

  assign bus.scl_lvl = scl_sync_reg[1];
  assign bus.sda_lvl = sda_sync_reg[1];
  assign bus.start_det = scl_sync_reg[1] & sda_last_reg & ~sda_sync_reg[1];
  assign bus.stop_det = scl_sync_reg[1] & ~sda_last_reg & sda_sync_reg[1];
  assign bus.scl_rise = scl_sync_reg[1] & ~scl_last_reg;
  // The clock fall that closes a start is not a data bit
  wire scl_fell = ~scl_sync_reg[1] & scl_last_reg;
  assign bus.scl_fall = scl_fell & ~skip_fall_reg;
  assign bus.bus_busy = busy_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_reg <= 1'b0;
    end else if (bus.start_det) begin
      busy_reg <= 1'b1;
    end else if (bus.stop_det) begin
      busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      skip_fall_reg <= 1'b0;
    end else if (bus.start_det) begin
      skip_fall_reg <= 1'b1;
    end else if (scl_fell) begin
      skip_fall_reg <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> src/iec_pkg.sv
`default_nettype none
package iec_pkg;
  // Register byte addresses on the APB
  localparam logic [19:0] ADDR_CONTROL_0 = 20'hf_0230;
  localparam logic [19:0] ADDR_STATUS = 20'hf_0238;
  localparam logic [19:0] ADDR_CONFIG = 20'hf_023c;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  // Control register fields
  localparam int CTL_ENABLE = 7;
  localparam int CTL_EXIT = 6;
  localparam int CTL_RELEASE = 5;
  localparam int CTL_STOP_IE = 4;
  localparam int CTL_WAIT_TIMING = 3;
  localparam int CTL_ACK_ENABLE = 2;
  localparam int CTL_START = 1;
  localparam int CTL_STOP = 0;
  // Config register fields: own address in 7:1, wakeup mode in 0
  localparam int CFG_ADDR_LSB = 1;
  localparam int CFG_WAKEUP = 0;
  // Byte framing
  localparam logic [3:0] CNT_LAST_DATA = 4'h7;
  localparam logic [3:0] CNT_ACK = 4'h8;
  localparam logic [4:0] EXT_CODE = 5'h1e;
  // Start and stop hold timing
  localparam int CLK_KHZ = 10000;
  localparam int HOLD_NS = 4000;
  localparam logic [7:0] HOLD_CYCLES =
    8'((HOLD_NS * CLK_KHZ + 999_999) / 1_000_000);
  typedef enum logic [2:0] {
    ST_IDLE, ST_START_HOLD, ST_MASTER, ST_STOP_LOW, ST_STOP_HIGH
  } iec_state_e;
endpackage
`default_nettype wire

// >>> test/iec_bus_model.sv
`default_nettype none
module iec_bus_model (
  input wire logic scl, // Resolved clock line
  input wire logic sda, // Resolved data line
  output logic scl_low, // Pull clock line low
  output logic sda_low // Pull data line low
);
  timeunit 1ns;
  timeprecision 1ns;
  int n_stall = 0;
  initial begin
    scl_low = 0;
    sda_low = 0;
  end
  // A stretched clock is waited out, but never forever
  task automatic hi_wait();
    int i;
    scl_low = 0;
    for (i = 0; i < 400 && scl !== 1'b1; i++) #100;
    if (scl !== 1'b1) n_stall++;
  endtask
  task automatic start();
    sda_low = 1;
    #400;
    scl_low = 1;
    #100;
  endtask
  // Data moves only 100 ns after the clock fell, so no false condition
  task automatic send(input logic [7:0] b);
    int i;
    for (i = 7; i >= 0; i--) begin
      sda_low = !b[i];
      #200;
      hi_wait();
      #400;
      scl_low = 1;
      #100;
    end
    sda_low = 0;
  endtask
  task automatic ninth(output logic ack);
    #200;
    hi_wait();
    ack = !sda;
    #400;
    scl_low = 1;
    #100;
  endtask
  task automatic stop();
    sda_low = 1;
    #300;
    hi_wait();
    #400;
    sda_low = 0;
    #400;
  endtask
endmodule
`default_nettype wire

// >>> test/iec_enable_exit_ctrl_sva.sv
`default_nettype none
module iec_eec_chk (
  input wire logic clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Write
  input wire logic [19:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [3:0] pstrb, // Strobes
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic scl_oe, // Clock drive
  input wire logic sda_oe, // Data drive
  input wire logic transfer_irq, // Transfer irq
  input wire logic stop_irq // Stop irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire acc = psel && penable;
  wire cw = acc && pwrite && pstrb[0] && paddr == iec_pkg::ADDR_CONTROL_0;
  wire mapped = paddr == iec_pkg::ADDR_CONTROL_0 ||
    paddr == iec_pkg::ADDR_STATUS || paddr == iec_pkg::ADDR_CONFIG;
  logic en_q;
  // Enable tracked from writes alone: the device never sets it itself
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst) en_q <= 1'b0;
    else if (cw) en_q <= pwdata[7];
  a_zero_wait: assert property (acc |-> pready)
    else $error("ready low in access phase");
  a_unmapped_err: assert property (acc && !mapped |-> pslverr)
    else $error("no error on unmapped address");
  a_mapped_ok: assert property (acc && mapped |-> !pslverr)
    else $error("error on mapped address");
  a_upper_zero: assert property (
    acc && !pwrite |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_exit_release: assert property (
    cw && pwdata[7:6] == 2'b11 && pwdata[1:0] == 2'b00
    |-> ##2 !scl_oe && !sda_oe)
    else $error("lines held after exit");
  a_disable_quiet: assert property (
    cw && !pwdata[7] |-> ##2 !scl_oe && !sda_oe)
    else $error("lines held after disable");
  a_off_silent: assert property (
    !en_q && !$past(en_q) |-> !scl_oe && !sda_oe && !transfer_irq &&
    !stop_irq)
    else $error("activity while disabled");
  a_tirq_pulse: assert property (transfer_irq |=> !transfer_irq)
    else $error("transfer irq longer than one cycle");
  a_sirq_pulse: assert property ($rose(stop_irq) |=> $fell(stop_irq))
    else $error("stop irq longer than one cycle");
endmodule
bind iec_enable_exit_ctrl iec_eec_chk u_chk (.clk(clk), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .scl_oe(scl_oe), .sda_oe(sda_oe),
  .transfer_irq(transfer_irq), .stop_irq(stop_irq));
`default_nettype wire

// >>> test/iec_enable_exit_ctrl_tb.sv
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
  n_mismatch++; $display("MISMATCH %0t %h %h", $time, g, e); end end
module iec_enable_exit_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [19:0] CTL = iec_pkg::ADDR_CONTROL_0;
  localparam logic [19:0] STA = iec_pkg::ADDR_STATUS;
  logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [19:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [3:0] pstrb = '0;
  logic pready, pslverr, scl_oe, sda_oe, tirq, sirq, m_scl, m_sda, ack, err;
  logic scl_o, sda_o;
  logic [7:0] rd, own, ctl_m = 8'h00;
  wire scl = !((scl_oe & !scl_o) | m_scl);
  wire sda = !((sda_oe & !sda_o) | m_sda);
  int n_mismatch = 0, n_compared = 0, n_ti = 0, n_si = 0, e_ti = 0;
  int e_si = 0, seed = 32'hd66d_9f90;
  iec_enable_exit_ctrl dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_in(scl), .scl_out(scl_o), .scl_oe(scl_oe), .sda_in(sda),
    .sda_out(sda_o), .sda_oe(sda_oe), .transfer_irq(tirq), .stop_irq(sirq));
  iec_bus_model bm (.scl(scl), .sda(sda), .scl_low(m_scl), .sda_low(m_sda));
  always #50 clk = !clk;
  always @(posedge clk) begin
    if (tirq === 1'b1) n_ti++;
    if (sirq === 1'b1) n_si++;
  end
  task automatic end_sim();
    if (n_mismatch == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [19:0] a,
      input logic [7:0] d, input logic [3:0] s);
    int i;
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    pstrb <= s;
    @(posedge clk);
    penable <= 1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_mismatch++;
      end_sim();
    end
    rd = prdata[7:0];
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rdchk(input logic [19:0] a, input logic [7:0] e,
      input logic [7:0] m = 8'hff);
    xfer(1'b0, a, 8'h00, 4'h0);
    `CHK(rd & m, e)
  endtask
  // Mirror of the control bits: config bits only while off or stretched
  task automatic wctl(input logic [7:0] w, input bit st);
    if (!ctl_m[7] || st) ctl_m[4:2] = w[4:2];
    ctl_m[7] = w[7];
    xfer(1'b1, CTL, w, 4'h1);
  endtask
  task automatic wait_oe(input logic [1:0] v, input int lim);
    int i;
    for (i = 0; i < lim && {scl_oe, sda_oe} !== v; i++) @(posedge clk);
    `CHK({scl_oe, sda_oe}, v)
    if ({scl_oe, sda_oe} !== v) end_sim();
  endtask
  task automatic irqs();
    repeat (8) @(posedge clk);
    `CHK(n_ti, e_ti)
    `CHK(n_si, e_si)
  endtask
  initial begin
    #5_000_000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    own = {1'b0, 2'b01, 5'($random(seed))};
    repeat (16) @(posedge clk);
    sys_rst <= 0;
    rdchk(CTL, 8'h00);
    rdchk(STA, 8'h00);
    xfer(1'b0, 20'hf_0234, 8'h00, 4'h0);
    `CHK(err, 1'b1)
    xfer(1'b1, iec_pkg::ADDR_CONFIG, {own[6:0], 1'b0}, 4'h1);
    rdchk(iec_pkg::ADDR_CONFIG, {own[6:0], 1'b0});
    wctl(8'h1c, 0);
    xfer(1'b1, CTL, 8'hff, 4'h0);
    rdchk(CTL, ctl_m);
    wctl(8'h94, 0);
    rdchk(CTL, ctl_m);
    wctl(8'h9c, 0);
    rdchk(CTL, ctl_m);
    wctl(8'hd4, 0);
    rdchk(CTL, ctl_m);
    rdchk(STA, 8'h01);
    bm.start();
    bm.send({own[6:0], 1'b0});
    e_ti++;
    irqs();
    rdchk(STA, 8'h40, 8'hf1);
    `CHK(scl_oe, 1'b1)
    wctl(8'hd4, 1);
    wait_oe(2'b00, 4);
    rdchk(STA, 8'h01);
    bm.ninth(ack);
    `CHK(ack, 1'b0)
    bm.stop();
    e_si++;
    irqs();
    rdchk(STA, 8'h00, 8'h01);
    bm.start();
    bm.send(8'hf0);
    e_ti++;
    irqs();
    rdchk(STA, 8'h20, 8'h21);
    wctl(8'hb4, 1);
    wait_oe(2'b01, 4);
    bm.ninth(ack);
    `CHK(ack, 1'b1)
    rdchk(CTL, ctl_m);
    wctl(8'hd4, 0);
    wait_oe(2'b00, 4);
    rdchk(STA, 8'h01);
    xfer(1'b1, iec_pkg::ADDR_CONFIG, {own[6:0], 1'b1}, 4'h1);
    bm.stop();
    irqs();
    xfer(1'b1, iec_pkg::ADDR_CONFIG, {own[6:0], 1'b0}, 4'h1);
    wctl(8'h96, 0);
    wait_oe(2'b01, 8);
    wait_oe(2'b11, 60);
    rdchk(STA, 8'h80, 8'h80);
    wctl(8'h95, 0);
    wait_oe(2'b00, 120);
    e_si++;
    irqs();
    wctl(8'h96, 0);
    wait_oe(2'b11, 60);
    wctl(8'h54, 0);
    wait_oe(2'b00, 3);
    rdchk(STA, 8'h00);
    rdchk(CTL, ctl_m);
    irqs();
    `CHK(bm.n_stall, 0)
    `CHK({scl_o, sda_o}, 2'b00)
    end_sim();
  end
endmodule
`default_nettype wire
